// ---- logic/shsx_datapath.sv ----
// Signed halving subtract / exchange datapath, one register stage.
// Assumes the decoder presents one operation per valid cycle together
// with operands, register indices, predicate outcome and current flags.
//
// Function
// - Condition flags leave the block exactly as they entered.
// - Halving add-sub exchange: upper = (first.hi + second.lo) halved.
// - Halving add-sub exchange: lower = (first.lo - second.hi) halved.
// - Halving sub-add exchange: upper = (first.hi - second.lo) halved.
// - Halving sub-add exchange: lower = (first.lo + second.hi) halved.
// - Halving halfword subtract: two 16-bit lanes, difference halved.
// - Halving byte subtract: four signed 8-bit lanes, difference halved.
// - Halfword lane subtract: two 16-bit differences, unshifted.
// - Byte lane subtract: four 8-bit differences, unshifted.
// - Add-sub exchange: upper = first.hi + second.lo, unshifted.
// - Failed predicate blocks the write; absent predicate always writes unless an index is forbidden.
// - Omitted destination means the first source register is written.
`timescale 1ns/1ps
`include "shsx_params.svh"

module shsx_datapath
  import shsx_pkg::*;
(
  input  wire logic                    clk_i,         // 250 MHz clock
  input  wire logic                    rst_i,         // Sync reset, high
  input  wire logic                    valid_i,       // Operation issued
  input  wire shsx_op_e                op_i,          // Operation select
  input  wire logic [`SHSX_WORD_W-1:0] first_src_i,   // First source value
  input  wire logic [`SHSX_WORD_W-1:0] second_src_i,  // Second source value
  input  wire logic [`SHSX_IDX_W-1:0]  first_idx_i,   // First source index
  input  wire logic [`SHSX_IDX_W-1:0]  second_idx_i,  // Second source index
  input  wire logic [`SHSX_IDX_W-1:0]  dest_idx_i,    // Destination index
  input  wire logic                    dest_given_i,  // Destination named
  input  wire logic                    cond_given_i,  // Predicate present
  input  wire logic                    cond_pass_i,   // Predicate holds
  input  wire logic [`SHSX_FLAG_W-1:0] flags_i,       // N Z C V Q in
  output logic                         valid_o,       // Result valid
  output logic                         wr_en_o,       // Write destination
  output logic      [`SHSX_IDX_W-1:0]  wr_idx_o,      // Written register
  output logic      [`SHSX_WORD_W-1:0] result_o,      // Result word
  output logic      [`SHSX_FLAG_W-1:0] flags_o,       // N Z C V Q out
  output logic                         bad_reg_o      // Forbidden index
);

  // Lane and exchange unit outputs
  logic [`SHSX_WORD_W-1:0] half_res;
  logic [`SHSX_WORD_W-1:0] byte_res;
  logic [`SHSX_WORD_W-1:0] xchg_res;
  logic                    halve;
  logic                    sub_hi;

  // Pipeline registers and their next values
  logic                    valid_reg;
  logic                    valid_next;
  logic                    wr_en_reg;
  logic                    wr_en_next;
  logic [`SHSX_IDX_W-1:0]  wr_idx_reg;
  logic [`SHSX_IDX_W-1:0]  wr_idx_next;
  logic [`SHSX_WORD_W-1:0] result_reg;
  logic [`SHSX_WORD_W-1:0] result_next;
  logic [`SHSX_FLAG_W-1:0] flags_reg;
  logic [`SHSX_FLAG_W-1:0] flags_next;
  logic                    bad_reg_reg;
  logic                    bad_reg_next;

  // Operation attributes: halve feeds all three units, sub_hi only the exchange unit
  always_comb begin
    halve  = 1'b0;
    sub_hi = 1'b0;
    unique case (op_i)
      SHSX_OP_HASX: begin
        halve = 1'b1;
      end
      SHSX_OP_HSAX: begin
        halve  = 1'b1;
        sub_hi = 1'b1;
      end
      SHSX_OP_HSUB16, SHSX_OP_HSUB8: begin
        halve = 1'b1;
      end
      SHSX_OP_SAX: begin
        sub_hi = 1'b1;
      end
      SHSX_OP_SUB16, SHSX_OP_SUB8, SHSX_OP_ASX: begin
        halve = 1'b0;
      end
    endcase
  end

  shsx_lane_sub #(
    .DATA_W (`SHSX_WORD_W),
    .LANE_W (`SHSX_HALF_W)
  ) u_half (
    .first_i  (first_src_i),
    .second_i (second_src_i),
    .halve_i  (halve),
    .diff_o   (half_res)
  );

  shsx_lane_sub #(
    .DATA_W (`SHSX_WORD_W),
    .LANE_W (`SHSX_BYTE_W)
  ) u_byte (
    .first_i  (first_src_i),
    .second_i (second_src_i),
    .halve_i  (halve),
    .diff_o   (byte_res)
  );

  shsx_exchange u_xchg (
    .first_i  (first_src_i),
    .second_i (second_src_i),
    .sub_hi_i (sub_hi),
    .halve_i  (halve),
    .res_o    (xchg_res)
  );

  // Next-state logic for the single result stage
  always_comb begin
    valid_next   = valid_i;
    flags_next   = flags_i;
    wr_idx_next  = dest_given_i ? dest_idx_i : first_idx_i;
    bad_reg_next = valid_i &&
                   (wr_idx_next == `SHSX_IDX_STACK ||
                    wr_idx_next == `SHSX_IDX_PROG ||
                    first_idx_i == `SHSX_IDX_STACK ||
                    first_idx_i == `SHSX_IDX_PROG ||
                    second_idx_i == `SHSX_IDX_STACK ||
                    second_idx_i == `SHSX_IDX_PROG);
    // predicate gates the write
    // Forbidden encodings also never write, to protect the core state
    wr_en_next   = valid_i && (!cond_given_i || cond_pass_i) &&
                   !bad_reg_next;
    result_next  = `SHSX_RST_WORD;
    unique case (op_i)
      SHSX_OP_HSUB16, SHSX_OP_SUB16: begin
        result_next = half_res;
      end
      SHSX_OP_HSUB8, SHSX_OP_SUB8: begin
        result_next = byte_res;
      end
      SHSX_OP_HASX, SHSX_OP_HSAX, SHSX_OP_ASX, SHSX_OP_SAX: begin
        result_next = xchg_res;
      end
    endcase
  end

  // Registers only; every output comes straight from here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_reg   <= 1'b0;
      wr_en_reg   <= 1'b0;
      wr_idx_reg  <= `SHSX_RST_IDX;
      result_reg  <= `SHSX_RST_WORD;
      flags_reg   <= `SHSX_RST_FLAG;
      bad_reg_reg <= 1'b0;
    end else begin
      valid_reg   <= valid_next;
      wr_en_reg   <= wr_en_next;
      wr_idx_reg  <= wr_idx_next;
      result_reg  <= result_next;
      flags_reg   <= flags_next;
      bad_reg_reg <= bad_reg_next;
    end
  end

  assign valid_o   = valid_reg;
  assign wr_en_o   = wr_en_reg;
  assign wr_idx_o  = wr_idx_reg;
  assign result_o  = result_reg;
  assign flags_o   = flags_reg;
  assign bad_reg_o = bad_reg_reg;

  // Reference sums built independently of the units, for checking only
  logic [`SHSX_HALF_W:0] chk_a_hi;
  logic [`SHSX_HALF_W:0] chk_a_lo;
  logic [`SHSX_HALF_W:0] chk_b_hi;
  logic [`SHSX_HALF_W:0] chk_b_lo;
  logic [`SHSX_BYTE_W:0] chk_a_b3;
  logic [`SHSX_BYTE_W:0] chk_a_b0;
  logic [`SHSX_BYTE_W:0] chk_b_b3;
  logic [`SHSX_BYTE_W:0] chk_b_b0;
  logic [`SHSX_HALF_W:0] chk_up_add;
  logic [`SHSX_HALF_W:0] chk_up_sub;
  logic [`SHSX_HALF_W:0] chk_dn_add;
  logic [`SHSX_HALF_W:0] chk_dn_sub;
  logic [`SHSX_HALF_W:0] chk_lane_hi;
  logic [`SHSX_HALF_W:0] chk_lane_lo;
  logic [`SHSX_BYTE_W:0] chk_byte3;
  logic [`SHSX_BYTE_W:0] chk_byte0;
  // Each lane view carries its own sign in one extra top bit
  assign chk_a_hi = {first_src_i[`SHSX_HI_MSB],
                     first_src_i[`SHSX_HI_MSB:`SHSX_HI_LSB]};
  assign chk_a_lo = {first_src_i[`SHSX_LO_MSB],
                     first_src_i[`SHSX_LO_MSB:`SHSX_LO_LSB]};
  assign chk_b_hi = {second_src_i[`SHSX_HI_MSB],
                     second_src_i[`SHSX_HI_MSB:`SHSX_HI_LSB]};
  assign chk_b_lo = {second_src_i[`SHSX_LO_MSB],
                     second_src_i[`SHSX_LO_MSB:`SHSX_LO_LSB]};
  assign chk_a_b3 = {first_src_i[`SHSX_HI_MSB],
                     first_src_i[`SHSX_HI_MSB -: `SHSX_BYTE_W]};
  assign chk_a_b0 = {first_src_i[`SHSX_BYTE_W-1],
                     first_src_i[`SHSX_LO_LSB +: `SHSX_BYTE_W]};
  assign chk_b_b3 = {second_src_i[`SHSX_HI_MSB],
                     second_src_i[`SHSX_HI_MSB -: `SHSX_BYTE_W]};
  assign chk_b_b0 = {second_src_i[`SHSX_BYTE_W-1],
                     second_src_i[`SHSX_LO_LSB +: `SHSX_BYTE_W]};
  // Wide sums and differences; halving later drops bit 0
  assign chk_up_add  = chk_a_hi + chk_b_lo;
  assign chk_up_sub  = chk_a_hi - chk_b_lo;
  assign chk_dn_add  = chk_a_lo + chk_b_hi;
  assign chk_dn_sub  = chk_a_lo - chk_b_hi;
  assign chk_lane_hi = chk_a_hi - chk_b_hi;
  assign chk_lane_lo = chk_a_lo - chk_b_lo;
  assign chk_byte3   = chk_a_b3 - chk_b_b3;
  assign chk_byte0   = chk_a_b0 - chk_b_b0;

  // flags pass unchanged one cycle later
  a_flags_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_i |=> flags_o == $past(flags_i))
    else $error("flags changed by datapath");

  a_hasx_word: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_i && op_i == SHSX_OP_HASX |=>
      result_o == {$past(chk_up_add[`SHSX_HALF_W:1]),
                   $past(chk_dn_sub[`SHSX_HALF_W:1])})
    else $error("halving add-sub exchange wrong");

  a_hsax_word: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_i && op_i == SHSX_OP_HSAX |=>
      result_o == {$past(chk_up_sub[`SHSX_HALF_W:1]),
                   $past(chk_dn_add[`SHSX_HALF_W:1])})
    else $error("halving sub-add exchange wrong");

  a_hsub16_hi: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_i && op_i == SHSX_OP_HSUB16 |=>
      result_o[`SHSX_HI_MSB:`SHSX_HI_LSB] ==
        $past(chk_lane_hi[`SHSX_HALF_W:1]))
    else $error("halving halfword lane wrong");

  a_hsub16_lo: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_i && op_i == SHSX_OP_HSUB16 |=>
      result_o[`SHSX_LO_MSB:`SHSX_LO_LSB] ==
        $past(chk_lane_lo[`SHSX_HALF_W:1]))
    else $error("halving lower halfword lane wrong");

  a_hsub8_top: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_i && op_i == SHSX_OP_HSUB8 |=>
      result_o[`SHSX_HI_MSB -: `SHSX_BYTE_W] ==
        $past(chk_byte3[`SHSX_BYTE_W:1]))
    else $error("halving byte lane wrong");

  a_hsub8_low: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_i && op_i == SHSX_OP_HSUB8 |=>
      result_o[`SHSX_LO_LSB +: `SHSX_BYTE_W] ==
        $past(chk_byte0[`SHSX_BYTE_W:1]))
    else $error("halving bottom byte lane wrong");

  a_sub16_hi: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_i && op_i == SHSX_OP_SUB16 |=>
      result_o[`SHSX_HI_MSB:`SHSX_HI_LSB] ==
        $past(chk_lane_hi[`SHSX_HALF_W-1:0]))
    else $error("halfword lane subtract wrong");

  a_sub8_top: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_i && op_i == SHSX_OP_SUB8 |=>
      result_o[`SHSX_HI_MSB -: `SHSX_BYTE_W] ==
        $past(chk_byte3[`SHSX_BYTE_W-1:0]))
    else $error("byte lane subtract wrong");

  a_asx_word: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_i && op_i == SHSX_OP_ASX |=>
      result_o == {$past(chk_up_add[`SHSX_HALF_W-1:0]),
                   $past(chk_dn_sub[`SHSX_HALF_W-1:0])})
    else $error("add-sub exchange wrong");

  a_sax_word: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_i && op_i == SHSX_OP_SAX |=>
      result_o == {$past(chk_up_sub[`SHSX_HALF_W-1:0]),
                   $past(chk_dn_add[`SHSX_HALF_W-1:0])})
    else $error("sub-add exchange wrong");

  a_cond_block: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_i && cond_given_i && !cond_pass_i |=> valid_o && !wr_en_o)
    else $error("write despite failed predicate");

  // absent predicate with legal indices always writes
  a_cond_absent: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_i && !cond_given_i |=> wr_en_o != bad_reg_o)
    else $error("unconditional operation not written");

  a_dest_default: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_i && !dest_given_i |=> wr_idx_o == $past(first_idx_i))
    else $error("default destination wrong");

  // program counter as write target raises the flag
  a_forbid_dest: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_i && dest_given_i && dest_idx_i == `SHSX_IDX_PROG |=>
      bad_reg_o && !wr_en_o)
    else $error("program counter destination not caught");

endmodule

// ---- logic/shsx_exchange.sv ----
// Cross-halfword add/subtract: upper of first meets lower of second and
// lower of first meets upper of second. Purely combinational.
`timescale 1ns/1ps
`include "shsx_params.svh"

module shsx_exchange (
  input  wire logic [`SHSX_WORD_W-1:0] first_i,  // First source word
  input  wire logic [`SHSX_WORD_W-1:0] second_i, // Second source word
  input  wire logic                    sub_hi_i, // Upper lane subtracts
  input  wire logic                    halve_i,  // Halve both lanes
  output logic      [`SHSX_WORD_W-1:0] res_o     // Exchanged result
);

  logic [`SHSX_HALF_W:0] a_hi;
  logic [`SHSX_HALF_W:0] a_lo;
  logic [`SHSX_HALF_W:0] b_hi;
  logic [`SHSX_HALF_W:0] b_lo;
  logic [`SHSX_HALF_W:0] up;
  logic [`SHSX_HALF_W:0] dn;

  // Sign-extend each halfword by one bit
  assign a_hi = {first_i[`SHSX_HI_MSB], first_i[`SHSX_HI_MSB:`SHSX_HI_LSB]};
  assign a_lo = {first_i[`SHSX_LO_MSB], first_i[`SHSX_LO_MSB:`SHSX_LO_LSB]};
  assign b_hi = {second_i[`SHSX_HI_MSB],
                 second_i[`SHSX_HI_MSB:`SHSX_HI_LSB]};
  assign b_lo = {second_i[`SHSX_LO_MSB],
                 second_i[`SHSX_LO_MSB:`SHSX_LO_LSB]};

  // Upper lane pairs first.hi with second.lo, lower the opposite pair
  assign up = sub_hi_i ? a_hi - b_lo : a_hi + b_lo;
  assign dn = sub_hi_i ? a_lo + b_hi : a_lo - b_hi;

  // Halving keeps the top bits, i.e. arithmetic shift of the wide value
  // arithmetic halving
  assign res_o = halve_i ? {up[`SHSX_HALF_W:1], dn[`SHSX_HALF_W:1]}
                         : {up[`SHSX_HALF_W-1:0], dn[`SHSX_HALF_W-1:0]};

endmodule

// ---- logic/shsx_lane_sub.sv ----
// Packed lane subtractor: first minus second in independent signed lanes.
// Assumes DATA_W is a whole multiple of LANE_W; purely combinational.
`timescale 1ns/1ps

module shsx_lane_sub #(
  parameter int DATA_W = 32,
  parameter int LANE_W = 16
) (
  input  wire logic [DATA_W-1:0] first_i,  // First source word
  input  wire logic [DATA_W-1:0] second_i, // Second source word
  input  wire logic              halve_i,  // Shift each lane right by one
  output logic      [DATA_W-1:0] diff_o    // Packed lane results
);

  // One extra bit per lane, so halving never overflows
  // wide lane arithmetic
  for (genvar g = 0; g < DATA_W / LANE_W; g++) begin : g_lane
    logic [LANE_W:0] wide;
    assign wide = {first_i[g*LANE_W+LANE_W-1], first_i[g*LANE_W +: LANE_W]}
                - {second_i[g*LANE_W+LANE_W-1], second_i[g*LANE_W +: LANE_W]};
    // Dropping bit 0 of the wide value is the arithmetic shift
    assign diff_o[g*LANE_W +: LANE_W] = halve_i ? wide[LANE_W:1]
                                                : wide[LANE_W-1:0];
  end

endmodule

// ---- logic/shsx_params.svh ----
// Constants for the signed halving subtract/exchange datapath.
// Assumes inclusion by bare name from the package and the datapath files.
`ifndef SHSX_PARAMS_SVH
`define SHSX_PARAMS_SVH

// Data path geometry
`define SHSX_WORD_W   32
`define SHSX_HALF_W   16
`define SHSX_BYTE_W   8
`define SHSX_FLAG_W   5
`define SHSX_IDX_W    4
`define SHSX_OP_W     3

// Halfword field positions
`define SHSX_HI_MSB   31
`define SHSX_HI_LSB   16
`define SHSX_LO_MSB   15
`define SHSX_LO_LSB   0

// Register indices the issuing stream may not name
`define SHSX_IDX_STACK 4'hD
`define SHSX_IDX_PROG  4'hF

// Reset values
`define SHSX_RST_WORD 32'h0000_0000
`define SHSX_RST_IDX  4'h0
`define SHSX_RST_FLAG 5'h00

`endif

// ---- logic/shsx_pkg.sv ----
// Types shared by the datapath, the register file model and the bench.
// Assumes shsx_params.svh is on the include path.
`include "shsx_params.svh"

package shsx_pkg;

  // Operation select from the instruction decoder
  typedef enum logic [`SHSX_OP_W-1:0] {
    SHSX_OP_HASX  = 3'h0,  // signed_halving_add_sub_exchange
    SHSX_OP_HSAX  = 3'h1,  // signed_halving_sub_add_exchange
    SHSX_OP_HSUB16 = 3'h2, // signed_halving_halfword_subtract
    SHSX_OP_HSUB8 = 3'h3,  // signed_halving_byte_subtract
    SHSX_OP_SUB16 = 3'h4,  // signed_halfword_lane_subtract
    SHSX_OP_SUB8  = 3'h5,  // signed_byte_lane_subtract
    SHSX_OP_ASX   = 3'h6,  // signed_add_sub_exchange
    SHSX_OP_SAX   = 3'h7   // signed_sub_add_exchange
  } shsx_op_e;

  typedef logic [`SHSX_WORD_W-1:0] shsx_word_t;
  typedef logic [`SHSX_IDX_W-1:0]  shsx_idx_t;

endpackage

// ---- verif/shsx_regfile_model.sv ----
// Register file model that takes the datapath's registered write port.
// Assumes writes arrive on clk_i as valid_o, wr_en_o, wr_idx_o, result_o.
`timescale 1ns/1ps
`include "shsx_params.svh"

module shsx_regfile_model
  import shsx_pkg::*;
(
  input  wire logic       clk_i,    // Core clock
  input  wire logic       rst_i,    // Sync reset, high
  input  wire logic       valid_i,  // Result presented
  input  wire logic       wr_en_i,  // Write request
  input  wire shsx_idx_t  wr_idx_i, // Written index
  input  wire shsx_word_t wr_val_i, // Written value
  input  wire shsx_idx_t  rd_idx_i, // Inspection index
  output shsx_word_t      rd_val_o  // Inspection value
);
  shsx_word_t regs_reg  [16];
  shsx_word_t regs_next [16];

  // Only a qualified write lands; a refused op leaves the file alone
  always_comb begin
    regs_next = regs_reg;
    if (valid_i && wr_en_i) begin
      regs_next[wr_idx_i] = wr_val_i;
    end
  end

  // Cleared on reset so the bench shadow can start from zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      regs_reg <= '{default: `SHSX_RST_WORD};
    end else begin
      regs_reg <= regs_next;
    end
  end

  assign rd_val_o = regs_reg[rd_idx_i]; // Peek only, no side effect
endmodule

// ---- verif/tb_shsx_datapath.sv ----
// Self-checking bench for the signed halving subtract/exchange datapath.
// Assumes the package, the design and the register file model are built.
`timescale 1ns/1ps
`include "shsx_params.svh"
`define CHK(g, e) chk(32'(g), 32'(e))

module tb_shsx_datapath import shsx_pkg::*;;
  logic       clk, rst, valid, dg, cg, cp, v_o, we_o, bad_o;
  shsx_op_e   op;
  shsx_word_t a, b, res_o, rd_val, e_res;
  shsx_idx_t  fi, si, di, wi_o, rd_idx, e_wi;
  logic [4:0] fl, fl_o, e_fl;
  logic       have, e_v, e_we, e_bad;
  shsx_word_t shadow [16];
  int         err_total, n_compared;

  shsx_datapath u_shsx_datapath (.clk_i(clk), .rst_i(rst), .valid_i(valid),
    .op_i(op), .first_src_i(a), .second_src_i(b), .first_idx_i(fi),
    .second_idx_i(si), .dest_idx_i(di), .dest_given_i(dg),
    .cond_given_i(cg), .cond_pass_i(cp), .flags_i(fl), .valid_o(v_o),
    .wr_en_o(we_o), .wr_idx_o(wi_o), .result_o(res_o), .flags_o(fl_o),
    .bad_reg_o(bad_o));
  shsx_regfile_model u_shsx_regfile_model (.clk_i(clk), .rst_i(rst),
    .valid_i(v_o), .wr_en_i(we_o), .wr_idx_i(wi_o), .wr_val_i(res_o),
    .rd_idx_i(rd_idx), .rd_val_o(rd_val));

  // 250 MHz clock
  always #2 clk = ~clk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Lane arithmetic at full int precision, then an arithmetic halving for the halving ops
  function automatic shsx_word_t exp_res(shsx_op_e o, shsx_word_t x,
                                         shsx_word_t y);
    int  p, q;
    bit  h;
    shsx_word_t r;
    h = o inside {SHSX_OP_HASX, SHSX_OP_HSAX, SHSX_OP_HSUB16, SHSX_OP_HSUB8};
    p = $signed(x[31:16]) - $signed(y[31:16]);
    q = $signed(x[15:0]) - $signed(y[15:0]);
    if (o inside {SHSX_OP_HASX, SHSX_OP_ASX}) begin
      p = $signed(x[31:16]) + $signed(y[15:0]);
      q = $signed(x[15:0]) - $signed(y[31:16]);
    end else if (o inside {SHSX_OP_HSAX, SHSX_OP_SAX}) begin
      p = $signed(x[31:16]) - $signed(y[15:0]);
      q = $signed(x[15:0]) + $signed(y[31:16]);
    end
    r = {16'(h ? p >>> 1 : p), 16'(h ? q >>> 1 : q)};
    if (o inside {SHSX_OP_HSUB8, SHSX_OP_SUB8}) begin
      for (int k = 0; k < 4; k++) begin
        p = $signed(x[8*k+:8]) - $signed(y[8*k+:8]);
        r[8*k+:8] = 8'(h ? p >>> 1 : p);
      end
    end
    return r;
  endfunction

  function automatic bit forbidden(shsx_idx_t i);
    return i == `SHSX_IDX_STACK || i == `SHSX_IDX_PROG;
  endfunction

  function automatic shsx_idx_t pick();
    shsx_idx_t r;
    do r = 4'($urandom_range(0, 14)); while (r == `SHSX_IDX_STACK);
    return r;
  endfunction

  // Compare what the previous issue should have produced
  task automatic check();
    if (!have) return;
    `CHK(v_o, e_v);
    `CHK(we_o, e_we);
    `CHK(fl_o, e_fl);
    if (e_v) begin
      `CHK(res_o, e_res);
      `CHK(wi_o, e_wi);
      `CHK(bad_o, e_bad);
    end
    if (e_we) shadow[e_wi] = e_res;
  endtask

  // One issue per cycle; checking the last one lets ops run back to back
  task automatic issue(input bit v, input shsx_op_e o, input shsx_word_t x,
                       input shsx_word_t y, input shsx_idx_t f,
                       input shsx_idx_t s, input shsx_idx_t d,
                       input bit g, input bit c, input bit p,
                       input logic [4:0] flg);
    @(posedge clk);
    #1;
    check();
    valid = v;
    op    = o;
    a     = x;
    b     = y;
    fi    = f;
    si    = s;
    di    = d;
    dg    = g;
    cg    = c;
    cp    = p;
    fl    = flg;
    e_v   = v;
    e_fl  = flg;
    e_res = exp_res(o, x, y);
    e_wi  = g ? d : f;
    // An omitted destination field is not a register reference
    e_bad = forbidden(f) || forbidden(s) || (g && forbidden(d));
    e_we  = v && !e_bad && (!c || p);
    have  = 1'b1;
  endtask

  initial begin
    #100000;
    err_total++;
    test_done();
  end

  initial begin
    shsx_word_t corner [6];
    corner = '{32'h8000_7FFF, 32'h7FFF_8000, 32'h807F_7F80,
               32'h7F80_807F, 32'hFFFF_0001, 32'h0001_FFFF};
    {clk, valid, dg, cg, cp, have} = '0;
    {a, b, fi, si, di, fl, rd_idx} = '0;
    op  = SHSX_OP_HASX;
    rst = 1'b1;
    shadow = '{default: `SHSX_RST_WORD};
    void'($urandom(32'hca746bac));
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    // Lane extremes for every operation, back to back
    for (int j = 0; j < 6; j += 2) begin
      for (int o = 0; o < 8; o++) begin
        issue(1, shsx_op_e'(o), corner[j], corner[j+1], pick(), pick(),
              pick(), 1'(o), 0, 0, 5'(o));
      end
    end
    $display("test corners done");
    // Reserved index in each position refuses the write; in an omitted
    // destination field it is ignored and the write lands
    for (int k = 0; k < 8; k++) begin
      issue(1, SHSX_OP_SUB8, $urandom, $urandom,
            k == 0 ? `SHSX_IDX_STACK : k == 1 ? `SHSX_IDX_PROG : 4'h1,
            k == 2 ? `SHSX_IDX_STACK : k == 3 ? `SHSX_IDX_PROG : 4'h2,
            k < 4 ? 4'h3 : k[0] ? `SHSX_IDX_PROG : `SHSX_IDX_STACK,
            k < 6, 0, 0, 5'h1F);
    end
    $display("test reserved done");
    // Random traffic with gaps, predicates and omitted destinations
    for (int n = 0; n < 400; n++) begin
      issue($urandom_range(0, 9) != 0, shsx_op_e'($urandom_range(0, 7)),
            $urandom, $urandom, pick(), pick(), pick(), 1'($urandom),
            1'($urandom), 1'($urandom), 5'($urandom));
    end
    issue(0, SHSX_OP_HASX, '0, '0, '0, '0, '0, 0, 0, 0, '0);
    issue(0, SHSX_OP_HASX, '0, '0, '0, '0, '0, 0, 0, 0, '0);
    @(posedge clk);
    // Written file must match the writes that were due
    for (int k = 0; k < 16; k++) begin
      rd_idx = 4'(k);
      #1;
      `CHK(rd_val, shadow[k]);
    end
    $display("test random done");
    test_done();
  end
endmodule
